// *** src/psrrs_regs.sv ***
// soft reset control and raw status registers
module psrrs_regs
  import psrrs_pkg::*;
(
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_b,
  // register strobes
  psrrs_apb_if.regs                   rif,
  // capability masks and raw conditions
  input  wire logic [31:0]            capability_mask_two,
  input  wire logic [31:0]            capability_mask_four,
  input  wire logic [PSRRS_RAW_W-1:0] raw_cond,
  // register contents
  output logic [31:0]                 periph_ff,
  output logic [31:0]                 gpio_ff,
  output logic [31:0]                 raw_ff
);
  function automatic logic [31:0] masked_wr(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [31:0] en);
    masked_wr = (old & ~en) | (wd & en);
  endfunction

  logic [31:0] nxt_periph;
  logic [31:0] nxt_gpio;
  assign nxt_periph = masked_wr(periph_ff, rif.wdata,
                                capability_mask_two & PSRRS_PERIPH_BITS);
  assign nxt_gpio   = masked_wr(gpio_ff, rif.wdata,
                                capability_mask_four & PSRRS_GPIO_BITS);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      periph_ff <= PSRRS_RESET_VAL;
    end else if (rif.wr_stb && rif.addr == PSRRS_OFF_PERIPH) begin
      periph_ff <= nxt_periph;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gpio_ff <= PSRRS_RESET_VAL;
    end else if (rif.wr_stb && rif.addr == PSRRS_OFF_GPIO) begin
      gpio_ff <= nxt_gpio;
    end
  end

  // hardware-only status, follows the conditions; bus writes are ignored
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      raw_ff <= PSRRS_RESET_VAL;
    end else begin
      raw_ff <= {{(32-PSRRS_RAW_W){1'b0}}, raw_cond};
    end
  end

  always_comb begin
    unique case (rif.addr)
      PSRRS_OFF_PERIPH: rif.rdata = periph_ff & PSRRS_PERIPH_BITS;
      PSRRS_OFF_GPIO:   rif.rdata = gpio_ff & PSRRS_GPIO_BITS;
      PSRRS_OFF_RAW:    rif.rdata = raw_ff & PSRRS_RAW_BITS;
      default:          rif.rdata = 32'h0000_0000;
    endcase
  end

  a_gated_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    (rif.wr_stb && rif.addr == PSRRS_OFF_PERIPH) |=>
      ((periph_ff ^ $past(periph_ff)) & ~$past(capability_mask_two)) == 32'h0)
    else $error("masked peripheral reset bit changed");
  a_gpio_gated: assert property (@(posedge core_clk) disable iff (!rst_b)
    (rif.wr_stb && rif.addr == PSRRS_OFF_GPIO) |=>
      gpio_ff == ((($past(gpio_ff) & ~$past(capability_mask_four))
                 | ($past(rif.wdata) & $past(capability_mask_four))) & PSRRS_GPIO_BITS))
    else $error("gpio reset write not masked correctly");
  a_periph_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    !(rif.wr_stb && rif.addr == PSRRS_OFF_PERIPH) |=> $stable(periph_ff))
    else $error("peripheral reset changed without write");
  a_periph_bits: assert property (@(posedge core_clk) disable iff (!rst_b)
    (periph_ff & ~PSRRS_PERIPH_BITS) == 32'h0)
    else $error("unimplemented peripheral bit set");
  a_periph_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    (rif.wr_stb && rif.addr == PSRRS_OFF_PERIPH && capability_mask_two[PSRRS_ASYNC_SERIAL_ZERO_RESET_BIT])
      |=> periph_ff[PSRRS_ASYNC_SERIAL_ZERO_RESET_BIT] == $past(rif.wdata[PSRRS_ASYNC_SERIAL_ZERO_RESET_BIT]))
    else $error("async serial zero bit not written");
  a_gpio_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    !(rif.wr_stb && rif.addr == PSRRS_OFF_GPIO) |=> $stable(gpio_ff))
    else $error("gpio reset changed without write");
  a_raw_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
    ##1 raw_ff[PSRRS_RAW_W-1:0] == $past(raw_cond))
    else $error("raw status does not follow conditions");
  a_raw_readonly: assert property (@(posedge core_clk) disable iff (!rst_b)
    (rif.wr_stb && rif.addr == PSRRS_OFF_RAW) |=> raw_ff[PSRRS_RAW_W-1:0] == $past(raw_cond))
    else $error("raw status taken a bus write");
  a_raw_upper: assert property (@(posedge core_clk) disable iff (!rst_b)
    raw_ff[31:PSRRS_RAW_W] == '0)
    else $error("raw status reserved bit set");
endmodule

// *** src/psrrs_pkg.sv ***
// constants shared by the soft reset and raw status slice
// How it works
// - writes to peripheral reset register change only bits enabled by capability mask two
// - writes to gpio reset register change only bits enabled by capability mask four
// - bits 18,17,16 reset timers two, one, zero; read-write, reset zero
// - bit 12 resets two-wire units, bit 4 sync serial units; reset zero
// - bit 1 resets async serial one, bit 0 async serial zero; reset zero
// - gpio register bits 4 to 0 reset banks e,d,c,b,a; reset zero
// - raw status register is read-only, hardware sets and clears, resets zero
// - raw status bits 6..0 hold lock, limit, osc faults, ldo, brownout, pll fault
package psrrs_pkg;
  localparam logic [11:0] PSRRS_OFF_PERIPH = 12'h044;
  localparam logic [11:0] PSRRS_OFF_GPIO   = 12'h048;
  localparam logic [11:0] PSRRS_OFF_RAW    = 12'h050;
  // implemented bits of each register
  localparam logic [31:0] PSRRS_PERIPH_BITS = 32'h0007_1013;
  localparam logic [31:0] PSRRS_GPIO_BITS   = 32'h0000_001f;
  localparam logic [31:0] PSRRS_RAW_BITS    = 32'h0000_007f;
  localparam logic [31:0] PSRRS_RESET_VAL   = 32'h0000_0000;
  localparam int PSRRS_TMR2_BIT = 18;
  localparam int PSRRS_TMR1_BIT = 17;
  localparam int PSRRS_TMR0_BIT = 16;
  localparam int PSRRS_TWI_BIT  = 12;
  localparam int PSRRS_SSER_BIT = 4;
  localparam int PSRRS_ASYNC_SERIAL_ONE_RESET_BIT = 1;
  localparam int PSRRS_ASYNC_SERIAL_ZERO_RESET_BIT = 0;
  localparam int PSRRS_GPIO_W   = 5;
  localparam int PSRRS_RAW_W    = 7;
endpackage

// *** src/psrrs_apb_if.sv ***
// register strobes between the bus slave and the register file
interface psrrs_apb_if;
  logic        wr_stb;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport slave (output wr_stb, output addr, output wdata, input rdata);
  modport regs  (input wr_stb, input addr, input wdata, output rdata);
endinterface

// *** src/psrrs_top.sv ***
// apb slave for the soft reset and raw status slice
module psrrs_top
  import psrrs_pkg::*;
(
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  // capability masks and raw conditions
  input  wire logic [31:0]             capability_mask_two,
  input  wire logic [31:0]             capability_mask_four,
  input  wire logic                    pll_lock_raw,
  input  wire logic                    current_limit_raw,
  input  wire logic                    internal_osc_fault_raw,
  input  wire logic                    main_osc_fault_raw,
  input  wire logic                    regulator_unregulated_raw,
  input  wire logic                    brownout_raw,
  input  wire logic                    pll_fault_raw,
  // peripheral resets, active high
  output logic                         timer_two_reset,
  output logic                         timer_one_reset,
  output logic                         timer_zero_reset,
  output logic                         two_wire_reset,
  output logic                         sync_serial_reset,
  output logic                         async_serial_one_reset,
  output logic                         async_serial_zero_reset,
  output logic [PSRRS_GPIO_W-1:0]      gpio_bank_reset
);
  psrrs_apb_if rif();
  logic [31:0] periph_ff;
  logic [31:0] gpio_ff;
  logic [31:0] raw_ff;
  logic        access;

  assign access     = psel && penable;
  assign pready     = 1'b1;
  assign pslverr    = 1'b0;
  assign rif.wr_stb = access && pwrite;
  assign rif.addr   = paddr;
  assign rif.wdata  = pwdata;
  assign prdata     = (access && !pwrite) ? rif.rdata : 32'h0000_0000;

  psrrs_regs u_regs (
    .core_clk             (core_clk),
    .rst_b                (rst_b),
    .rif                  (rif),
    .capability_mask_two  (capability_mask_two),
    .capability_mask_four (capability_mask_four),
    .raw_cond             ({pll_lock_raw, current_limit_raw, internal_osc_fault_raw,
                            main_osc_fault_raw, regulator_unregulated_raw, brownout_raw,
                            pll_fault_raw}),
    .periph_ff            (periph_ff),
    .gpio_ff              (gpio_ff),
    .raw_ff               (raw_ff)
  );

  // resets held while the control bit is one
  assign timer_two_reset         = periph_ff[PSRRS_TMR2_BIT];
  assign timer_one_reset         = periph_ff[PSRRS_TMR1_BIT];
  assign timer_zero_reset        = periph_ff[PSRRS_TMR0_BIT];
  assign two_wire_reset          = periph_ff[PSRRS_TWI_BIT];
  assign sync_serial_reset       = periph_ff[PSRRS_SSER_BIT];
  assign async_serial_one_reset  = periph_ff[PSRRS_ASYNC_SERIAL_ONE_RESET_BIT];
  assign async_serial_zero_reset = periph_ff[PSRRS_ASYNC_SERIAL_ZERO_RESET_BIT];
  assign gpio_bank_reset         = gpio_ff[PSRRS_GPIO_W-1:0];

  a_reset_follows: assert property (@(posedge core_clk) disable iff (!rst_b)
    (access && pwrite && paddr == PSRRS_OFF_GPIO && capability_mask_four[0])
      |=> gpio_bank_reset[0] == $past(pwdata[0]))
    else $error("gpio bank a reset does not follow write");
endmodule

// *** bench/test_peripheral_soft_reset_and_raw_status.sv ***
// self-checking bench for the soft reset and raw status slice
module test_peripheral_soft_reset_and_raw_status import psrrs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, mask_two, mask_four;
  logic [6:0]  raw_in;
  logic        tmr2, tmr1, tmr0, twi, ssr, as1, as0;
  logic [4:0]  gpio_rst;
  logic [31:0] outs;
  int          errors, total_checks;
  assign outs = {13'h0, tmr2, tmr1, tmr0, 3'h0, twi, 7'h0, ssr, 2'h0, as1, as0};
  psrrs_top DUT (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capability_mask_two(mask_two), .capability_mask_four(mask_four),
    .pll_lock_raw(raw_in[6]), .current_limit_raw(raw_in[5]),
    .internal_osc_fault_raw(raw_in[4]), .main_osc_fault_raw(raw_in[3]),
    .regulator_unregulated_raw(raw_in[2]), .brownout_raw(raw_in[1]),
    .pll_fault_raw(raw_in[0]), .timer_two_reset(tmr2), .timer_one_reset(tmr1),
    .timer_zero_reset(tmr0), .two_wire_reset(twi), .sync_serial_reset(ssr),
    .async_serial_one_reset(as1), .async_serial_zero_reset(as0),
    .gpio_bank_reset(gpio_rst));
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer, entered and left just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    repeat (20) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    if (pready !== 1'b1) begin
      errors++;
      stop_test();
    end
    cmp("pslverr", 32'h0, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    cmp(what, exp, q);
  endtask
  task automatic t_reset();
    rd(PSRRS_OFF_PERIPH, 32'h0, "periph reset value");
    rd(PSRRS_OFF_GPIO, 32'h0, "gpio reset value");
    rd(PSRRS_OFF_RAW, 32'h0, "raw reset value");
    cmp("reset outputs", 32'h0, outs);
    cmp("gpio reset outputs", 32'h0, {27'h0, gpio_rst});
  endtask
  task automatic t_periph();
    mask_two <= 32'hffff_ffff;
    wr(PSRRS_OFF_PERIPH, 32'h0007_1013);
    rd(PSRRS_OFF_PERIPH, 32'h0007_1013, "periph all set");
    cmp("periph outputs set", 32'h0007_1013, outs);
    mask_two <= 32'h0001_0001;
    wr(PSRRS_OFF_PERIPH, 32'h0);
    rd(PSRRS_OFF_PERIPH, 32'h0006_1012, "periph masked clear");
    cmp("periph outputs masked", 32'h0006_1012, outs);
  endtask
  task automatic t_gpio();
    mask_four <= 32'h0000_0015;
    wr(PSRRS_OFF_GPIO, 32'h0000_001f);
    rd(PSRRS_OFF_GPIO, 32'h0000_0015, "gpio masked set");
    cmp("gpio outputs", 32'h0000_0015, {27'h0, gpio_rst});
    mask_four <= 32'hffff_ffff;
    wr(PSRRS_OFF_GPIO, 32'h0);
    cmp("gpio outputs released", 32'h0, {27'h0, gpio_rst});
  endtask
  task automatic t_raw();
    raw_in <= 7'h55;
    @(posedge core_clk);
    rd(PSRRS_OFF_RAW, 32'h0000_0055, "raw pattern a");
    wr(PSRRS_OFF_RAW, 32'h0000_002a);
    rd(PSRRS_OFF_RAW, 32'h0000_0055, "raw after write");
    raw_in <= 7'h2a;
    @(posedge core_clk);
    rd(PSRRS_OFF_RAW, 32'h0000_002a, "raw pattern b");
    rd(12'h04c, 32'h0, "unmapped read");
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    mask_two = 32'h0;
    mask_four = 32'h0;
    raw_in = 7'h0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_periph();
    t_gpio();
    t_raw();
    stop_test();
  end
endmodule
